/* logic/bsc_device.sv */
// Sensor device end: register file, acquisition control, threshold events
// Contract
// - Diff is measured minus reference; output raw.
// - Auto-ref bit self-clears; host clears mode.
// - Setting auto-ref captures next pressure as reference.
// - Threshold is 15-bit unsigned, hPa times 16.
// - Events need diff enable and one side.
// - High above threshold, low below negative.
// - Threshold split low 7:0, high 14:8.
// - Pad pull-up and pull-down control bits.
// - Two-wire port disable bit; both on.
// - Rate select decode, reset zero.
// - Top two rates force low-noise off.
// - Rate zero is power-down, outputs kept.
// - One-shot only from power-down, self-clears.
// - Nonzero rate acquires every period.
// - Bandwidth OUTPUT_RATE_SELECT/2, OUTPUT_RATE_SELECT/9 or OUTPUT_RATE_SELECT/20.
// - Hold outputs until all three bytes read.
// - Host reads pressure high byte last.
// - Host should enable hold when slow.
// - Three-wire select chooses SPI wiring.
// - Acquisition control bit layout, bit 7 zero.
module bsc_device #(
    parameter int         TICK_CYCLES = bsc_pkg::TICK_CYCLES,
    parameter logic [7:0] IDENT_CODE  = 8'h5A  // Arbitrary value
) (
    input  wire logic    clk_sys,
    input  wire logic    rst,
    bsc_link_if.dev      link,
    output logic         acq_start,
    input  wire logic    acq_done,
    input  wire logic [23:0] meas_pressure,
    input  wire logic [15:0] meas_temp,
    output logic         low_noise_active,
    output logic [4:0]   bandwidth_divisor,
    output logic         data_line_pullup_enable,
    output logic         serial_out_pullup_enable,
    output logic         irq_pin_pulldown_disable,
    output logic         two_wire_port_disable,
    output logic         three_wire_select
);
    initial begin
        if (TICK_CYCLES < 2) begin
            $error("TICK_CYCLES must be at least 2");
        end
    end

    typedef enum logic {ACQ_IDLE, ACQ_BUSY} bsc_acq_t;

    logic [7:0]  int_cfg_reg, ths_low_reg, ths_high_reg, if_ctrl_reg;
    logic [7:0]  acq_ctrl_reg, ctrl_two_reg, int_src_reg, rdata_reg;
    logic [15:0] ref_reg;
    logic        aref_active_reg, ack_reg, acq_start_reg;
    logic [23:0] prs_out_reg;
    logic [15:0] tmp_out_reg;
    logic [2:0]  read_mask_reg;
    logic [31:0] tick_cnt_reg;
    logic [9:0]  rate_cnt_reg;
    bsc_acq_t    acq_state_reg;
    logic [4:0]  bw_reg;
    logic        ln_reg;

    logic        wr_hit, rd_hit, period_hit, os_start, start_now, done_now;
    logic [2:0]  output_rate_select;
    logic [14:0] threshold_value;
    logic signed [16:0] diff_pressure;
    logic        high_evt, low_evt;

    // Ticks of base rate per output period
    function automatic logic [9:0] period_ticks(input logic [2:0] sel);
        case (bsc_pkg::bsc_odr_t'(sel))
            bsc_pkg::BSC_ODR_1:   period_ticks = 10'd600;
            bsc_pkg::BSC_ODR_10:  period_ticks = 10'd60;
            bsc_pkg::BSC_ODR_25:  period_ticks = 10'd24;
            bsc_pkg::BSC_ODR_50:  period_ticks = 10'd12;
            bsc_pkg::BSC_ODR_75:  period_ticks = 10'd8;
            bsc_pkg::BSC_ODR_100: period_ticks = 10'd6;
            bsc_pkg::BSC_ODR_200: period_ticks = 10'd3;
            default:              period_ticks = 10'd1;
        endcase
    endfunction

    assign wr_hit = link.req && !ack_reg && link.we;
    assign rd_hit = link.req && !ack_reg && !link.we;
    assign output_rate_select    = acq_ctrl_reg[6:4];
    assign done_now = (acq_state_reg == ACQ_BUSY) && acq_done;

    assign os_start = wr_hit && link.addr == bsc_pkg::ADR_CTRL_TWO
                      && link.wdata[bsc_pkg::B_ONE_SHOT]
                      && output_rate_select == 3'h0 && !ctrl_two_reg[bsc_pkg::B_ONE_SHOT];
    // no start with rate zero except one-shot
    assign start_now = acq_state_reg == ACQ_IDLE
                       && (ctrl_two_reg[bsc_pkg::B_ONE_SHOT]
                           || (output_rate_select != 3'h0 && period_hit));

    assign threshold_value = {ths_high_reg[6:0], ths_low_reg};
    assign diff_pressure = $signed({1'b0, meas_pressure[23:8]})
                           - $signed({1'b0, ref_reg});
    // compare against positive and negative threshold
    assign high_evt = diff_pressure > $signed({2'b00, threshold_value});
    assign low_evt  = diff_pressure < -$signed({2'b00, threshold_value});

    // Link answer and read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= bsc_pkg::RST_ZERO;
        end else begin
            ack_reg <= link.req && !ack_reg;
            if (rd_hit) begin
                case (link.addr)
                    bsc_pkg::ADR_INT_CFG:  rdata_reg <= int_cfg_reg;
                    bsc_pkg::ADR_THS_LOW:  rdata_reg <= ths_low_reg;
                    bsc_pkg::ADR_THS_HIGH: rdata_reg <= ths_high_reg;
                    bsc_pkg::ADR_IF_CTRL:  rdata_reg <= if_ctrl_reg;
                    bsc_pkg::ADR_IDENT:    rdata_reg <= IDENT_CODE;
                    bsc_pkg::ADR_ACQ_CTRL: rdata_reg <= acq_ctrl_reg;
                    bsc_pkg::ADR_CTRL_TWO: rdata_reg <= ctrl_two_reg;
                    bsc_pkg::ADR_REF_LOW:  rdata_reg <= ref_reg[7:0];
                    bsc_pkg::ADR_REF_HIGH: rdata_reg <= ref_reg[15:8];
                    bsc_pkg::ADR_INT_SRC:  rdata_reg <= int_src_reg;
                    bsc_pkg::ADR_PRS_XL:   rdata_reg <= prs_out_reg[7:0];
                    bsc_pkg::ADR_PRS_L:    rdata_reg <= prs_out_reg[15:8];
                    bsc_pkg::ADR_PRS_H:    rdata_reg <= prs_out_reg[23:16];
                    bsc_pkg::ADR_TMP_L:    rdata_reg <= tmp_out_reg[7:0];
                    bsc_pkg::ADR_TMP_H:    rdata_reg <= tmp_out_reg[15:8];
                    default:               rdata_reg <= bsc_pkg::RST_ZERO;
                endcase
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ths_low_reg  <= bsc_pkg::RST_ZERO;
            ths_high_reg <= bsc_pkg::RST_ZERO;
            if_ctrl_reg  <= bsc_pkg::RST_ZERO;
            acq_ctrl_reg <= bsc_pkg::RST_ZERO;
        end else if (wr_hit) begin
            case (link.addr)
                bsc_pkg::ADR_THS_LOW:  ths_low_reg <= link.wdata;
                bsc_pkg::ADR_THS_HIGH:
                    ths_high_reg <= link.wdata & bsc_pkg::MSK_THS_HIGH;
                bsc_pkg::ADR_IF_CTRL:
                    if_ctrl_reg <= link.wdata & bsc_pkg::MSK_IF_CTRL;
                bsc_pkg::ADR_ACQ_CTRL:
                    acq_ctrl_reg <= link.wdata & bsc_pkg::MSK_ACQ_CTRL;
                default: ;
            endcase
        end
    end

    // Control two, one-shot self-clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_two_reg <= bsc_pkg::RST_CTRL_TWO;
        end else begin
            if (wr_hit && link.addr == bsc_pkg::ADR_CTRL_TWO) begin
                ctrl_two_reg <= (link.wdata & bsc_pkg::MSK_CTRL_TWO)
                                | {7'h00, os_start};
            end else if (done_now) begin
                ctrl_two_reg[bsc_pkg::B_ONE_SHOT] <= 1'b0;
            end
        end
    end

    // Interrupt configuration and auto-reference
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_cfg_reg     <= bsc_pkg::RST_ZERO;
            ref_reg         <= 16'h0000;
            aref_active_reg <= 1'b0;
        end else begin
            if (done_now && int_cfg_reg[bsc_pkg::B_AREF_EN]) begin
                ref_reg         <= meas_pressure[23:8];
                aref_active_reg <= 1'b1;
                int_cfg_reg[bsc_pkg::B_AREF_EN] <= 1'b0;
            end
            if (wr_hit && link.addr == bsc_pkg::ADR_INT_CFG) begin
                // Write wins over self-clear
                int_cfg_reg <= link.wdata & bsc_pkg::MSK_INT_CFG;
                // clear bit returns to normal mode
                if (link.wdata[bsc_pkg::B_AREF_CLR]) begin
                    aref_active_reg <= 1'b0;
                end
            end
        end
    end

    // Threshold event flags, cleared on read, set wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_src_reg <= bsc_pkg::RST_ZERO;
        end else begin
            if (rd_hit && link.addr == bsc_pkg::ADR_INT_SRC) begin
                int_src_reg <= bsc_pkg::RST_ZERO;
            end
            // gated by diff enable and side enables
            if (done_now && aref_active_reg
                && int_cfg_reg[bsc_pkg::B_DIFF_INTERRUPT_ENABLE]) begin
                if (int_cfg_reg[bsc_pkg::B_PHE] && high_evt) begin
                    int_src_reg[bsc_pkg::B_SRC_PH] <= 1'b1;
                    int_src_reg[bsc_pkg::B_SRC_IA] <= 1'b1;
                end
                if (int_cfg_reg[bsc_pkg::B_PLE] && low_evt) begin
                    int_src_reg[bsc_pkg::B_SRC_PL] <= 1'b1;
                    int_src_reg[bsc_pkg::B_SRC_IA] <= 1'b1;
                end
            end
        end
    end

    // Output data with block update hold
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prs_out_reg   <= 24'h000000;
            tmp_out_reg   <= 16'h0000;
            read_mask_reg <= 3'h7;
        end else begin
            if (rd_hit && link.addr >= bsc_pkg::ADR_PRS_XL
                && link.addr <= bsc_pkg::ADR_PRS_H) begin
                read_mask_reg[link.addr[1:0]] <= 1'b1;
            end
            // hold until all three bytes read
            if (done_now && (!acq_ctrl_reg[bsc_pkg::B_BDU]
                             || read_mask_reg == 3'h7)) begin
                prs_out_reg   <= meas_pressure;
                tmp_out_reg   <= meas_temp;
                read_mask_reg <= 3'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 32'h00000000;
            rate_cnt_reg <= 10'h000;
            period_hit   <= 1'b0;
        end else begin
            period_hit <= 1'b0;
            if (output_rate_select == 3'h0) begin
                tick_cnt_reg <= 32'h00000000;
                rate_cnt_reg <= 10'h000;
            end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
                tick_cnt_reg <= 32'h00000000;
                if (rate_cnt_reg >= period_ticks(output_rate_select) - 10'd1) begin
                    rate_cnt_reg <= 10'h000;
                    period_hit   <= 1'b1;
                end else begin
                    rate_cnt_reg <= rate_cnt_reg + 10'd1;
                end
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'd1;
            end
        end
    end

    // Acquisition sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acq_state_reg <= ACQ_IDLE;
            acq_start_reg <= 1'b0;
        end else begin
            acq_start_reg <= 1'b0;
            case (acq_state_reg)
                ACQ_IDLE: begin
                    if (start_now) begin
                        acq_start_reg <= 1'b1;
                        acq_state_reg <= ACQ_BUSY;
                    end
                end
                ACQ_BUSY: begin
                    if (acq_done) begin
                        acq_state_reg <= ACQ_IDLE;
                    end
                end
                default: acq_state_reg <= ACQ_IDLE;
            endcase
        end
    end

    // Analog mode outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bw_reg <= 5'd2;
            ln_reg <= 1'b0;
        end else begin
            if (!acq_ctrl_reg[bsc_pkg::B_LPF_EN]) begin
                bw_reg <= 5'd2;
            end else if (acq_ctrl_reg[bsc_pkg::B_LPF_CFG]) begin
                bw_reg <= 5'd20;
            end else begin
                bw_reg <= 5'd9;
            end
            ln_reg <= ctrl_two_reg[bsc_pkg::B_LOW_NOISE]
                      && output_rate_select != 3'h6 && output_rate_select != 3'h7;
        end
    end

    assign link.ack     = ack_reg;
    assign link.rdata   = rdata_reg;
    assign link.irq_pin = int_src_reg[bsc_pkg::B_SRC_IA];
    assign acq_start         = acq_start_reg;
    assign low_noise_active  = ln_reg;
    assign bandwidth_divisor = bw_reg;
    assign data_line_pullup_enable  = if_ctrl_reg[bsc_pkg::B_SDA_PU];
    assign serial_out_pullup_enable = if_ctrl_reg[bsc_pkg::B_SDO_PU];
    assign irq_pin_pulldown_disable = if_ctrl_reg[bsc_pkg::B_PD_DIS];
    assign two_wire_port_disable    = if_ctrl_reg[bsc_pkg::B_I2C_DIS];
    assign three_wire_select = acq_ctrl_reg[bsc_pkg::B_SIM];
endmodule

/* logic/bsc_pkg.sv */
// Shared constants for the barometric sensor control link and both ends
package bsc_pkg;
    localparam int          ADDR_W       = 7;
    localparam int          DATA_W       = 8;
    // Device register offsets
    localparam logic [6:0]  ADR_INT_CFG  = 7'h0B;
    localparam logic [6:0]  ADR_THS_LOW  = 7'h0C;
    localparam logic [6:0]  ADR_THS_HIGH = 7'h0D;
    localparam logic [6:0]  ADR_IF_CTRL  = 7'h0E;
    localparam logic [6:0]  ADR_IDENT    = 7'h0F;
    localparam logic [6:0]  ADR_ACQ_CTRL = 7'h10;
    localparam logic [6:0]  ADR_CTRL_TWO = 7'h11;
    localparam logic [6:0]  ADR_REF_LOW  = 7'h15;
    localparam logic [6:0]  ADR_REF_HIGH = 7'h16;
    localparam logic [6:0]  ADR_INT_SRC  = 7'h24;
    localparam logic [6:0]  ADR_PRS_XL   = 7'h28;
    localparam logic [6:0]  ADR_PRS_L    = 7'h29;
    localparam logic [6:0]  ADR_PRS_H    = 7'h2A;
    localparam logic [6:0]  ADR_TMP_L    = 7'h2B;
    localparam logic [6:0]  ADR_TMP_H    = 7'h2C;
    // Field positions
    localparam int          B_AREF_EN    = 7;
    localparam int          B_AREF_CLR   = 6;
    localparam int          B_DIFF_INTERRUPT_ENABLE    = 3;
    localparam int          B_LATCH      = 2;
    localparam int          B_PLE        = 1;
    localparam int          B_PHE        = 0;
    localparam int          B_SDA_PU     = 4;
    localparam int          B_SDO_PU     = 3;
    localparam int          B_PD_DIS     = 2;
    localparam int          B_I2C_DIS    = 0;
    localparam int          B_LPF_EN     = 3;
    localparam int          B_LPF_CFG    = 2;
    localparam int          B_BDU        = 1;
    localparam int          B_SIM        = 0;
    localparam int          B_ADD_INC    = 4;
    localparam int          B_LOW_NOISE  = 1;
    localparam int          B_ONE_SHOT   = 0;
    localparam int          B_SRC_PH     = 0;
    localparam int          B_SRC_PL     = 1;
    localparam int          B_SRC_IA     = 2;
    // Reset values and masks
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam logic [7:0]  RST_CTRL_TWO = 8'h10;
    localparam logic [7:0]  MSK_INT_CFG  = 8'h8F;
    localparam logic [7:0]  MSK_THS_HIGH = 8'h7F;
    localparam logic [7:0]  MSK_IF_CTRL  = 8'h1D;
    localparam logic [7:0]  MSK_ACQ_CTRL = 8'h7F;
    localparam logic [7:0]  MSK_CTRL_TWO = 8'h12;
    // Timing: base tick of 1/600 s serves every rate as whole ticks
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          BASE_TICK_HZ = 600;
    localparam int          TICK_CYCLES  = CLK_HZ / BASE_TICK_HZ;
    // Host APB register offsets
    localparam logic [11:0] APB_CMD      = 12'h000;
    localparam logic [11:0] APB_STATUS   = 12'h004;
    localparam int          CMD_WDATA_LO = 8;
    localparam int          CMD_WRITE    = 16;
    localparam int          ST_BUSY      = 8;
    localparam int          ST_IRQ       = 9;
    typedef enum logic [2:0] {
        BSC_ODR_OFF, BSC_ODR_1, BSC_ODR_10, BSC_ODR_25,
        BSC_ODR_50, BSC_ODR_75, BSC_ODR_100, BSC_ODR_200
    } bsc_odr_t;
endpackage

/* logic/bsc_link_if.sv */
// Register access link between host controller and sensor device
interface bsc_link_if;
    logic       req;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       irq_pin;
    modport dev (
        input  req, we, addr, wdata,
        output rdata, ack, irq_pin
    );
    modport host (
        output req, we, addr, wdata,
        input  rdata, ack, irq_pin
    );
endinterface

/* logic/bsc_host.sv */
// Host controller end: APB command registers driving the register link
module bsc_host (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    bsc_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic       req_reg, we_reg;
    logic [6:0] addr_reg;
    logic [7:0] wdata_reg, rdata_reg;
    logic       apb_acc, cmd_go;
    logic [31:0] prdata_next;

    assign apb_acc = psel && penable;
    // Software via these commands
    assign cmd_go  = apb_acc && pwrite && paddr == bsc_pkg::APB_CMD
                     && !req_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            addr_reg  <= 7'h00;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            if (cmd_go) begin
                req_reg   <= 1'b1;
                we_reg    <= pwdata[bsc_pkg::CMD_WRITE];
                addr_reg  <= pwdata[6:0];
                wdata_reg <= pwdata[bsc_pkg::CMD_WDATA_LO +: 8];
            end else if (req_reg && link.ack) begin
                req_reg <= 1'b0;
                if (!we_reg) begin
                    rdata_reg <= link.rdata;
                end
            end
        end
    end

    always_comb begin
        prdata_next = 32'h00000000;
        if (paddr == bsc_pkg::APB_CMD) begin
            prdata_next = {15'h0000, we_reg, wdata_reg, 1'b0, addr_reg};
        end else if (paddr == bsc_pkg::APB_STATUS) begin
            prdata_next = {22'h000000, link.irq_pin, req_reg, rdata_reg};
        end
    end

    assign prdata  = prdata_next;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && paddr != bsc_pkg::APB_CMD
                     && paddr != bsc_pkg::APB_STATUS;
    assign link.req   = req_reg;
    assign link.we    = we_reg;
    assign link.addr  = addr_reg;
    assign link.wdata = wdata_reg;
endmodule

/* bench/bsc_link_props.sv */
// Checker for the register link between host and device ends
module bsc_link_props #(
    parameter logic [7:0] IDENT_CODE = 8'h3C
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       req,
    input wire logic       we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    link_answer_a: assert property (req && !ack |=> ack)
        else $error("link request not answered in one cycle");
    ack_pulse_a: assert property (ack |=> !ack && !req)
        else $error("ack or request held too long");
    req_hold_a: assert property (req && !ack |=>
        $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    ident_fixed_a: assert property (ack && !we && addr == bsc_pkg::ADR_IDENT
        |-> rdata == IDENT_CODE)
        else $error("identity read wrong");
    ths_high_a: assert property (ack && !we &&
        addr == bsc_pkg::ADR_THS_HIGH |-> !rdata[7])
        else $error("threshold high bit 7 not zero");
    acq_bit7_a: assert property (ack && !we &&
        addr == bsc_pkg::ADR_ACQ_CTRL |-> !rdata[7])
        else $error("acquisition control bit 7 not zero");
    if_ctrl_a: assert property (ack && !we && addr == bsc_pkg::ADR_IF_CTRL
        |-> (rdata & ~bsc_pkg::MSK_IF_CTRL) == 8'h00)
        else $error("interface control fixed bits not zero");
    aref_clr_a: assert property (ack && !we &&
        addr == bsc_pkg::ADR_INT_CFG |-> !rdata[6])
        else $error("auto reference clear bit reads one");
endmodule

/* bench/tb.sv */
// Testbench joining host and device ends over the register link
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] IDENT = 8'h3C;  // Arbitrary value
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, acq_start, acq_done = 0, low_noise_active;
    logic [23:0] meas_pressure = 24'h0, p1, p2, p3;
    logic [15:0] meas_temp = 16'h0;
    logic [4:0] bandwidth_divisor;
    logic dpu, spu, pdd, i2c_off, three_w;
    logic [7:0] exp_q[$], got, d, ex;
    string name_q[$], nm;
    event seen_ev;
    int fails = 0, checks_done = 0, acq_cnt = 0, n0;
    always #4 clk_sys = ~clk_sys;
    bsc_link_if bsc_link_if_inst ();
    bsc_device #(.TICK_CYCLES(4), .IDENT_CODE(IDENT)) bsc_device_inst (
        .clk_sys(clk_sys), .rst(rst), .link(bsc_link_if_inst.dev),
        .acq_start(acq_start), .acq_done(acq_done),
        .meas_pressure(meas_pressure), .meas_temp(meas_temp),
        .low_noise_active(low_noise_active),
        .bandwidth_divisor(bandwidth_divisor),
        .data_line_pullup_enable(dpu), .serial_out_pullup_enable(spu),
        .irq_pin_pulldown_disable(pdd), .two_wire_port_disable(i2c_off),
        .three_wire_select(three_w));
    bsc_host bsc_host_inst (
        .clk_sys(clk_sys), .rst(rst), .link(bsc_link_if_inst.host),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    bsc_link_props #(.IDENT_CODE(IDENT)) bsc_link_props_inst (
        .clk_sys(clk_sys), .rst(rst), .req(bsc_link_if_inst.req),
        .we(bsc_link_if_inst.we), .addr(bsc_link_if_inst.addr),
        .wdata(bsc_link_if_inst.wdata), .rdata(bsc_link_if_inst.rdata),
        .ack(bsc_link_if_inst.ack), .irq_pin(bsc_link_if_inst.irq_pin));
    // Conversion answers one cycle after each start
    always @(posedge clk_sys) begin
        acq_done <= acq_start;
        if (acq_done === 1'b1) acq_cnt++;
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic dev_op(input logic w, input logic [6:0] a,
                          input logic [7:0] wd, output logic [7:0] rd);
        logic [31:0] s;
        apb(1, bsc_pkg::APB_CMD, {15'h0, w, wd, 1'b0, a}, s);
        for (int i = 0; i < 20; i++) begin
            apb(0, bsc_pkg::APB_STATUS, 32'h0, s);
            if (s[8] === 1'b0) break;
        end
        rd = s[7:0];
    endtask
    task automatic note(input string n, input logic [7:0] e, g);
        exp_q.push_back(e);
        name_q.push_back(n);
        got = g;
        ->seen_ev;
        @(posedge clk_sys);
    endtask
    task automatic rd(input string n, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        dev_op(0, a, 8'h00, v);
        note(n, e, v);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] x;
        dev_op(1, a, v, x);
    endtask
    task automatic shot(input logic [23:0] p);
        meas_pressure <= p;
        n0 = acq_cnt;
        wr(bsc_pkg::ADR_CTRL_TWO, 8'h11);
        for (int i = 0; i < 60 && acq_cnt == n0; i++) @(posedge clk_sys);
    endtask
    always begin
        @(seen_ev);
        nm = name_q.pop_front();
        ex = exp_q.pop_front();
        `CHK(nm, ex, got)
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial begin
        logic [7:0] bw[3] = '{8'h02, 8'h09, 8'h14};
        logic [7:0] cv[3] = '{8'h60, 8'h58, 8'h5C};
        void'($urandom(38228));
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rd("ths_low", bsc_pkg::ADR_THS_LOW, 8'h00);
        rd("acq_ctrl", bsc_pkg::ADR_ACQ_CTRL, 8'h00);
        rd("if_ctrl", bsc_pkg::ADR_IF_CTRL, 8'h00);
        note("i2c_off", 8'h00, {7'h0, i2c_off});
        note("bw_reset", 8'h02, {3'h0, bandwidth_divisor});
        $display("reset test done");
        d = 8'($urandom);
        wr(bsc_pkg::ADR_THS_HIGH, d);
        rd("ths_high", bsc_pkg::ADR_THS_HIGH, d & 8'h7F);
        wr(bsc_pkg::ADR_IDENT, ~IDENT);
        rd("ident", bsc_pkg::ADR_IDENT, IDENT);
        d = 8'($urandom) | 8'h80;
        wr(bsc_pkg::ADR_ACQ_CTRL, d);
        rd("acq_rand", bsc_pkg::ADR_ACQ_CTRL, d & 8'h7F);
        wr(bsc_pkg::ADR_IF_CTRL, 8'hFF);
        rd("if_all", bsc_pkg::ADR_IF_CTRL, 8'h1D);
        note("pins", 8'h0F, {4'h0, dpu, spu, pdd, i2c_off});
        $display("register test done");
        wr(bsc_pkg::ADR_CTRL_TWO, 8'h12);
        for (int i = 0; i < 3; i++) begin
            wr(bsc_pkg::ADR_ACQ_CTRL, cv[i] | 8'h01);
            note("bw", bw[i], {3'h0, bandwidth_divisor});
            note("low_noise", {7'h0, i > 0}, {7'h0, low_noise_active});
            note("three_wire", 8'h01, {7'h0, three_w});
        end
        // Starts in 120 cycles at the two fastest rates
        for (int i = 6; i < 8; i++) begin
            wr(bsc_pkg::ADR_ACQ_CTRL, 8'(i << 4));
            @(posedge acq_start);
            n0 = acq_cnt;
            repeat (120) @(posedge clk_sys);
            note("rate", 8'(5 * (i - 5)), 8'(acq_cnt - n0));
        end
        wr(bsc_pkg::ADR_ACQ_CTRL, 8'h00);
        n0 = acq_cnt;
        repeat (60) @(posedge clk_sys);
        note("power_down", 8'h00, 8'(acq_cnt - n0));
        $display("rate test done");
        p1 = {8'h40, 16'($urandom)};
        p2 = p1 + 24'h001100;
        wr(bsc_pkg::ADR_THS_LOW, 8'h10);
        wr(bsc_pkg::ADR_THS_HIGH, 8'h00);
        wr(bsc_pkg::ADR_INT_CFG, 8'h89);
        shot(p1);
        rd("one_shot", bsc_pkg::ADR_CTRL_TWO, 8'h10);
        rd("aref_off", bsc_pkg::ADR_INT_CFG, 8'h09);
        rd("ref_low", bsc_pkg::ADR_REF_LOW, p1[15:8]);
        rd("ref_high", bsc_pkg::ADR_REF_HIGH, p1[23:16]);
        shot(p2);
        apb(0, bsc_pkg::APB_STATUS, 32'h0, r);
        note("irq", 8'h01, {7'h0, r[bsc_pkg::ST_IRQ]});
        rd("src_high", bsc_pkg::ADR_INT_SRC, 8'h05);
        for (int i = 0; i < 3; i++)
            rd("press", 7'(bsc_pkg::ADR_PRS_XL + i), p2[8*i+:8]);
        p3 = p1 - 24'h001100;
        shot(p3);
        rd("src_low_off", bsc_pkg::ADR_INT_SRC, 8'h00);
        wr(bsc_pkg::ADR_ACQ_CTRL, 8'h02);
        shot(p2);
        for (int i = 0; i < 3; i++)
            rd("held", 7'(bsc_pkg::ADR_PRS_XL + i), p3[8*i+:8]);
        shot(p2);
        rd("released", bsc_pkg::ADR_PRS_H, p2[23:16]);
        rd("src_again", bsc_pkg::ADR_INT_SRC, 8'h05);
        wr(bsc_pkg::ADR_INT_CFG, 8'h49);
        shot(p2);
        rd("src_aref_off", bsc_pkg::ADR_INT_SRC, 8'h00);
        $display("reference test done");
        complete_run();
    end
endmodule
